// ==== hdl/hmi_cfg.svh ====
// Register indexes, field positions and reset values of the monitor block
`ifndef HMI_CFG_SVH
`define HMI_CFG_SVH

// Register indexes; byte address on the bus is four times the index
`define HMI_IDX_OVT       8'h18
`define HMI_IDX_CFG       8'h40
`define HMI_IDX_ST1       8'h41
`define HMI_IDX_ST2       8'h42
`define HMI_IDX_MSK1      8'h43
`define HMI_IDX_MSK2      8'h44
`define HMI_IDX_CASECLR   8'h46
`define HMI_IDX_EVT       8'h50
`define HMI_IDX_EVTMSK    8'h51

// Reset values
`define HMI_RST_CFG       8'h03
`define HMI_RST_MSK1      8'hDE
`define HMI_RST_MSK2      8'hFF
`define HMI_RST_OVT       8'h43
`define HMI_RST_EVTMSK    2'h0

// Configuration fields
`define HMI_CFG_INIT      7
`define HMI_CFG_INTCLR    3
`define HMI_CFG_IRQEN     1
`define HMI_CFG_START     0
`define HMI_CFG_WMASK     8'h0B

// Over-temperature configuration fields
`define HMI_OVT_DIS       6
`define HMI_OVT_MODE      4
`define HMI_OVT_WMASK     8'h50

// Status 2 fields
`define HMI_ST2_CASE      4
`define HMI_CASECLR_BIT   7

`endif

// ==== hdl/hmi_pkg.sv ====
// Types shared by the monitor interrupt block and its users
package hmi_pkg;

	// Monitor conditions; the first eight follow status 1 from bit 7 down
	typedef struct packed {
		logic processor_fan_tach;
		logic system_fan_tach;
		logic processor_temp_input;
		logic system_temp_input;
		logic five_volt_supply;
		logic analog_supply;
		logic voltage_input_zero;
		logic processor_core_voltage;
		logic processor_target_overrun;
		logic system_target_overrun;
		logic case_open;
		logic voltage_input_two;
		logic voltage_input_one;
	} hmi_src_t;

	// Classic Wishbone request from the master
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [31:0] adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} hmi_wb_req_t;

endpackage

// ==== hdl/hmi_monitor_irq.sv ====
// Control, status and interrupt logic of the hardware monitor
`timescale 1ns/1ps
`default_nettype none
`include "hmi_cfg.svh"

// Operation
// - Init bit restores config, mask 1/2 and over-temperature defaults, self clears
// - Int-clear masks output, halts monitoring
// - Config bit 1 gates interrupt output
// - Config bit 0 starts monitoring, resets 0x03
// - Clearing start leaves active interrupt asserted
// - Status 1 bits 7,6: fan limits
// - Status 1 bits 5,4: temperature limits
// - Status 1 bits 3-0: supply limits
// - Status 2 bits 7,6: target overrun
// - Status 2 bit 4: case opened
// - Status 2 bits 2,0: inputs 2,1
// - Mask 1 blocks status 1 bits
// - Mask 2 blocks status 2, resets ones
// - Status registers read-only, reset zero
// - Over-temperature output: comparator, interrupt, disable
// - Case-clear control clears intrusion, self clears
module hmi_monitor_irq (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Wishbone slave
	input  wire hmi_pkg::hmi_wb_req_t wb_req_i,
	output logic [31:0]            wb_dat_o,
	output logic                   wb_ack_o,
	// Monitor conditions
	input  wire hmi_pkg::hmi_src_t src_i,
	input  wire logic              sys_temp_over_i,
	// Status and interrupt outputs
	output logic                   monitor_run_o,
	output logic                   restore_defaults_o,
	output logic                   mgmt_interrupt_out_o,
	output logic                   ovt_o,
	output logic                   irq_o
);
	import hmi_pkg::*;

	logic [7:0] cfg_reg,     cfg_next;
	logic [7:0] st1_reg,     st1_next;
	logic [7:0] st2_reg,     st2_next;
	logic [7:0] msk1_reg,    msk1_next;
	logic [7:0] msk2_reg,    msk2_next;
	logic [7:0] ovt_cfg_reg, ovt_cfg_next;
	logic       caseclr_reg;
	logic       ovt_latch_reg, ovt_latch_next;
	logic       ovt_reg,     ovt_next;
	logic       temp_prev_reg;
	logic [1:0] evt_reg,     evt_next;
	logic [1:0] evtmsk_reg,  evtmsk_next;
	logic       mgmt_reg,    mgmt_next;
	logic       irq_reg;
	logic       ack_reg;
	logic       restore_reg;
	logic [7:0] dat_reg,     rd_mux;

	wire        req;
	wire        wr;
	wire        rd;
	wire        in_map;
	wire [7:0]  idx;
	wire [7:0]  wdat;
	wire        restore;
	wire        active;
	wire [7:0]  st1_set;
	wire [7:0]  st2_set;
	wire [7:0]  st2_keep;
	wire [7:0]  case_bit;
	wire        temp_rise;
	wire [1:0]  evt_set;

	// Register hit for a given index
	function automatic logic hit(input logic [7:0] i);
		return in_map && (idx == i);
	endfunction

	// Bus decode; one wait state, ack drops the cycle after it rises
	assign req    = wb_req_i.cyc & wb_req_i.stb & ~ack_reg;
	assign wr     = req & wb_req_i.we & wb_req_i.sel[0];
	assign rd     = req & ~wb_req_i.we;
	assign in_map = (wb_req_i.adr[31:10] == 22'h0) &
	                (wb_req_i.adr[1:0] == 2'h0);
	assign idx    = wb_req_i.adr[9:2];
	assign wdat   = wb_req_i.dat[7:0];

	assign restore = wr & hit(`HMI_IDX_CFG) & wdat[`HMI_CFG_INIT];

	// Monitoring runs only when started and not held by int-clear
	assign active = cfg_reg[`HMI_CFG_START] &
	                ~cfg_reg[`HMI_CFG_INTCLR];

	// Status 1 sources, gated by monitoring
	assign st1_set = active ? src_i[12:5] : 8'h00;

	// Status 2 sources; intrusion is watched even in standby
	assign st2_set = {active & src_i.processor_target_overrun,
	                  active & src_i.system_target_overrun,
	                  1'b0,
	                  src_i.case_open,
	                  1'b0,
	                  active & src_i.voltage_input_two,
	                  1'b0,
	                  active & src_i.voltage_input_one};

	assign case_bit = 8'h01 << `HMI_ST2_CASE;

	// Read clears status 2 except intrusion, which has its own clear
	assign st2_keep = ~((rd & hit(`HMI_IDX_ST2)) ? ~case_bit : 8'h00) &
	                  ~(caseclr_reg ? case_bit : 8'h00);

	// Sticky status, new condition wins over a clear; no write path
	assign st1_next = st1_set |
	                  (st1_reg & ~{8{rd & hit(`HMI_IDX_ST1)}});
	assign st2_next = st2_set | (st2_reg & st2_keep);

	// Configuration; init write loads defaults and never stores itself
	always_comb begin
		cfg_next = cfg_reg;
		if (restore) begin
			cfg_next = `HMI_RST_CFG;
		end else if (wr && hit(`HMI_IDX_CFG)) begin
			cfg_next = wdat & `HMI_CFG_WMASK;
		end
	end

	always_comb begin
		msk1_next = msk1_reg;
		msk2_next = msk2_reg;
		ovt_cfg_next = ovt_cfg_reg;
		if (restore) begin
			msk1_next    = `HMI_RST_MSK1;
			msk2_next    = `HMI_RST_MSK2;
			ovt_cfg_next = `HMI_RST_OVT;
		end else begin
			if (wr && hit(`HMI_IDX_MSK1)) begin
				msk1_next = wdat;
			end
			if (wr && hit(`HMI_IDX_MSK2)) begin
				msk2_next = wdat;
			end
			if (wr && hit(`HMI_IDX_OVT)) begin
				ovt_cfg_next = (ovt_cfg_reg & ~`HMI_OVT_WMASK) |
				               (wdat & `HMI_OVT_WMASK);
			end
		end
	end

	// Management interrupt; start bit plays no part here
	assign mgmt_next = cfg_reg[`HMI_CFG_IRQEN] &
	                   ~cfg_reg[`HMI_CFG_INTCLR] &
	                   (|((st1_reg & ~msk1_reg) |
	                      (st2_reg & ~msk2_reg)));

	// Over-temperature: comparator follows input, interrupt mode latches
	assign temp_rise = active & sys_temp_over_i & ~temp_prev_reg;
	assign ovt_latch_next = temp_rise |
	                        (ovt_latch_reg & ~(rd & hit(`HMI_IDX_ST1)));
	assign ovt_next = ~ovt_cfg_reg[`HMI_OVT_DIS] &
	                  (ovt_cfg_reg[`HMI_OVT_MODE] ? ovt_latch_reg
	                                              : sys_temp_over_i);

	// Block events: new status bit, over-temperature assertion
	assign evt_set = {ovt_next & ~ovt_reg,
	                  |((st1_set & ~st1_reg) | (st2_set & ~st2_reg))};
	assign evt_next = evt_set |
	                  (evt_reg & ~((wr && hit(`HMI_IDX_EVT)) ?
	                               wdat[1:0] : 2'h0));
	assign evtmsk_next = (wr && hit(`HMI_IDX_EVTMSK)) ? wdat[1:0]
	                                                   : evtmsk_reg;

	// Read data; unmapped or reserved locations read zero
	always_comb begin
		rd_mux = 8'h00;
		if (hit(`HMI_IDX_CFG)) begin
			rd_mux = cfg_reg;
		end else if (hit(`HMI_IDX_ST1)) begin
			rd_mux = st1_reg;
		end else if (hit(`HMI_IDX_ST2)) begin
			rd_mux = st2_reg;
		end else if (hit(`HMI_IDX_MSK1)) begin
			rd_mux = msk1_reg;
		end else if (hit(`HMI_IDX_MSK2)) begin
			rd_mux = msk2_reg;
		end else if (hit(`HMI_IDX_OVT)) begin
			rd_mux = ovt_cfg_reg;
		end else if (hit(`HMI_IDX_CASECLR)) begin
			rd_mux = {caseclr_reg, 7'h00};
		end else if (hit(`HMI_IDX_EVT)) begin
			rd_mux = {6'h00, evt_reg};
		end else if (hit(`HMI_IDX_EVTMSK)) begin
			rd_mux = {6'h00, evtmsk_reg};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_reg     <= `HMI_RST_CFG;
			msk1_reg    <= `HMI_RST_MSK1;
			msk2_reg    <= `HMI_RST_MSK2;
			ovt_cfg_reg <= `HMI_RST_OVT;
			st1_reg     <= 8'h00;
			st2_reg     <= 8'h00;
		end else begin
			cfg_reg     <= cfg_next;
			msk1_reg    <= msk1_next;
			msk2_reg    <= msk2_next;
			ovt_cfg_reg <= ovt_cfg_next;
			st1_reg     <= st1_next;
			st2_reg     <= st2_next;
		end
	end

	// Case-clear pulse lasts one cycle, then clears itself
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			caseclr_reg <= 1'b0;
		end else begin
			caseclr_reg <= wr & hit(`HMI_IDX_CASECLR) &
			               wdat[`HMI_CASECLR_BIT];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ovt_latch_reg <= 1'b0;
			ovt_reg       <= 1'b0;
			temp_prev_reg <= 1'b0;
			mgmt_reg      <= 1'b0;
			evt_reg       <= 2'h0;
			evtmsk_reg    <= `HMI_RST_EVTMSK;
			irq_reg       <= 1'b0;
		end else begin
			ovt_latch_reg <= ovt_latch_next;
			ovt_reg       <= ovt_next;
			temp_prev_reg <= sys_temp_over_i;
			mgmt_reg      <= mgmt_next;
			evt_reg       <= evt_next;
			evtmsk_reg    <= evtmsk_next;
			irq_reg       <= |(evt_reg & ~evtmsk_reg);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg     <= 1'b0;
			dat_reg     <= 8'h00;
			restore_reg <= 1'b0;
		end else begin
			ack_reg     <= req;
			restore_reg <= restore;
			if (rd) begin
				dat_reg <= rd_mux;
			end
		end
	end

	assign wb_ack_o             = ack_reg;
	assign wb_dat_o             = {24'h00_0000, dat_reg};
	assign monitor_run_o        = active;
	assign restore_defaults_o   = restore_reg;
	assign mgmt_interrupt_out_o = mgmt_reg;
	assign ovt_o                = ovt_reg;
	assign irq_o                = irq_reg;

endmodule // hmi_monitor_irq
`default_nettype wire

// ==== tb/hmi_host_model.sv ====
// Host side that counts management interrupt assertions
`timescale 1ns/1ps
`default_nettype none
module hmi_host_model (
	// Clock and interrupt line
	input  wire logic clk_i,
	input  wire logic irq_i,
	// Count of rising edges
	output int        edges_o
);
	logic last_reg = 1'h0;
	initial edges_o = 0;
	always @(posedge clk_i) begin
		if (irq_i && !last_reg) edges_o <= edges_o + 1;
		last_reg <= irq_i;
	end
endmodule // hmi_host_model
`default_nettype wire

// ==== tb/hmi_monitor_irq_assertions.sv ====
// Port checker of the monitor interrupt block
`timescale 1ns/1ps
`default_nettype none
module hmi_chk (
	input wire logic                 clk_i,
	input wire logic                 rst_i,
	input wire hmi_pkg::hmi_wb_req_t wb_req_i,
	input wire logic [31:0]          wb_dat_o,
	input wire logic                 wb_ack_o,
	input wire hmi_pkg::hmi_src_t    src_i,
	input wire logic                 sys_temp_over_i,
	input wire logic                 monitor_run_o,
	input wire logic                 restore_defaults_o,
	input wire logic                 mgmt_interrupt_out_o,
	input wire logic                 ovt_o,
	input wire logic                 irq_o
);
	import hmi_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire logic req = wb_req_i.cyc && wb_req_i.stb;
	wire logic rd = req && !wb_req_i.we;
	wire logic [31:0] a = wb_req_i.adr;
	chk_ack_answer: assert property (req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack timing wrong");
	chk_ack_idle: assert property (!req |=> !wb_ack_o)
		else $error("ack without request");
	chk_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("upper read bits set");
	chk_init_cause: assert property (restore_defaults_o |->
		$past(req && wb_req_i.we && a == 32'h100 && wb_req_i.dat[7]))
		else $error("restore pulse without init write");
	chk_init_run: assert property (restore_defaults_o |->
		monitor_run_o ##1 !restore_defaults_o)
		else $error("restore did not start monitor");
	chk_cfg_reserved: assert property (wb_ack_o && $past(rd && a == 32'h100)
		|-> (wb_dat_o[7:0] & 8'hF4) == 8'h00)
		else $error("config reserved bits set");
	chk_st2_reserved: assert property (wb_ack_o && $past(rd && a == 32'h108)
		|-> (wb_dat_o[7:0] & 8'h2A) == 8'h00)
		else $error("status two reserved bits set");
	chk_out_sticky: assert property (mgmt_interrupt_out_o && !req &&
		!$past(req) && !$past(req, 2) |=> mgmt_interrupt_out_o)
		else $error("interrupt dropped without service");
	cover property ($rose(mgmt_interrupt_out_o));
	cover property (restore_defaults_o);
	cover property ($rose(ovt_o));
endmodule // hmi_chk
bind hmi_monitor_irq hmi_chk u_chk (.clk_i, .rst_i, .wb_req_i, .wb_dat_o,
	.wb_ack_o, .src_i, .sys_temp_over_i, .monitor_run_o, .restore_defaults_o,
	.mgmt_interrupt_out_o, .ovt_o, .irq_o);
`default_nettype wire

// ==== tb/test_hw_monitor_irq_control.sv ====
// Self-checking bench of the monitor interrupt block
`timescale 1ns/1ps
`default_nettype none
module test_hw_monitor_irq_control;
	import hmi_pkg::*;
	logic        clk_i = 1'h0;
	logic        rst_i = 1'h1;
	hmi_wb_req_t req = '0;
	hmi_src_t    src = '0;
	logic        ovt_in = 1'h0;
	logic [31:0] dat;
	logic        ack, run, rdo, mgmt, ovt, irq;
	logic [7:0]  q;
	int          fails = 0;
	int          samples_checked = 0;
	int          cyc_n = 0;
	int          edges;
	always #25 clk_i = ~clk_i;
	hmi_monitor_irq dut (.clk_i, .rst_i, .wb_req_i(req), .wb_dat_o(dat),
		.wb_ack_o(ack), .src_i(src), .sys_temp_over_i(ovt_in),
		.monitor_run_o(run), .restore_defaults_o(rdo),
		.mgmt_interrupt_out_o(mgmt), .ovt_o(ovt), .irq_o(irq));
	hmi_host_model host (.clk_i, .irq_i(mgmt), .edges_o(edges));
	task automatic chk(input string n, input logic [7:0] e, g);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	// Classic single cycle; request held until the edge that sees ack
	task automatic wb(input logic w, input logic [7:0] i, d);
		req.cyc <= 1'h1;
		req.stb <= 1'h1;
		req.we <= w;
		req.adr <= {22'h0, i, 2'h0};
		req.sel <= 4'hF;
		req.dat <= {24'h0, d};
		do @(posedge clk_i); while (ack !== 1'h1);
		q = dat[7:0];
		req.cyc <= 1'h0;
		req.stb <= 1'h0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] i, e);
		wb(1'h0, i, 8'h00);
		chk($sformatf("reg %h", i), e, q);
	endtask
	// Outputs as {run, mgmt, ovt, irq}
	task automatic outs(input logic [3:0] e);
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		chk("outs", {4'h0, e}, {4'h0, run, mgmt, ovt, irq});
		@(posedge clk_i);
	endtask
	task automatic pulse(input hmi_src_t s);
		src <= s;
		@(posedge clk_i);
		src <= '0;
	endtask
	task automatic t_reset();
		rd(8'h40, 8'h03);
		rd(8'h43, 8'hDE);
		rd(8'h44, 8'hFF);
		rd(8'h42, 8'h00);
		wb(1'h1, 8'h41, 8'hFF);
		rd(8'h41, 8'h00);
		rd(8'h7F, 8'h00);
		outs(4'h8);
	endtask
	task automatic t_status();
		wb(1'h1, 8'h51, 8'h03);
		wb(1'h1, 8'h43, 8'h00);
		wb(1'h1, 8'h44, 8'h00);
		pulse('1);
		outs(4'hC);
		rd(8'h41, 8'hFF);
		rd(8'h42, 8'hD5);
		rd(8'h41, 8'h00);
		rd(8'h42, 8'h10);
		outs(4'hC);
		wb(1'h1, 8'h46, 8'h80);
		rd(8'h42, 8'h00);
		outs(4'h8);
		chk("rises", 8'h01, {7'h0, edges > 0});
	endtask
	task automatic t_gate();
		pulse(13'h0020);
		wb(1'h1, 8'h40, 8'h02);
		outs(4'h4);
		wb(1'h1, 8'h40, 8'h0B);
		outs(4'h0);
		rd(8'h41, 8'h01);
		pulse(13'h0020);
		rd(8'h41, 8'h00);
		wb(1'h1, 8'h40, 8'h01);
		pulse(13'h0020);
		outs(4'h8);
		wb(1'h1, 8'h43, 8'h01);
		wb(1'h1, 8'h40, 8'h03);
		outs(4'h8);
		wb(1'h1, 8'h40, 8'h80);
		rd(8'h43, 8'hDE);
		rd(8'h40, 8'h03);
		outs(4'hC);
		rd(8'h41, 8'h01);
		outs(4'h8);
	endtask
	task automatic t_ovt();
		wb(1'h1, 8'h18, 8'h00);
		ovt_in <= 1'h1;
		outs(4'hA);
		ovt_in <= 1'h0;
		outs(4'h8);
		wb(1'h1, 8'h18, 8'h10);
		wb(1'h1, 8'h51, 8'h00);
		pulse('0);
		ovt_in <= 1'h1;
		pulse('0);
		ovt_in <= 1'h0;
		outs(4'hB);
		rd(8'h41, 8'h00);
		outs(4'h9);
		wb(1'h1, 8'h50, 8'h03);
		wb(1'h1, 8'h18, 8'h50);
		ovt_in <= 1'h1;
		outs(4'h8);
		ovt_in <= 1'h0;
	endtask
	task automatic results();
		$display("checks %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc_n++;
		if (cyc_n > 5000) begin
			fails++;
			results();
		end
	end
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		t_reset();
		t_status();
		t_gate();
		t_ovt();
		results();
	end
endmodule // test_hw_monitor_irq_control
`default_nettype wire
